// ---- logic/pmcg_power_mode_clock_gating.v ----
// Operating-mode controller choosing gated clock domains and divider settings
// How it works
// - Debugger request turns every clock domain on
// - Reset enters run mode, divider divide-by-16
// - Each mode enables its own clock set
// - Sleep mode gates off the bus clock
// - Deep modes force a divide by 16
// - Wake controller enabled gives wake deep sleep
// - Enable request selects wake deep versus deep
// - Keep-awake bit 21 keeps peripheral clocks
// - Tick timer stops in deep modes
// - Wake controller records pending wake interrupts
// - Wake deep sleep without keep-awake: crystal off, outer divide 128
// - No stop mode; primary clock never gated
// - Fast clock request in modes needing PLL
// - Wake controller acknowledges enable request
// - Wake request only for enabled wake sources
// - Outer divider 128 in wake deep without keep-awake, back after wake
// - Core divider supports 1, 2, 4, 8, 16
`timescale 1ns/1ps
`default_nettype none
`include "pmcg_regs.vh"

module pmcg_power_mode_clock_gating (
	// System
	input wire clk_sys,
	input wire sys_rst,
	// Register port
	input wire [7:0] regAddr,
	input wire [31:0] regWdata,
	input wire regWrite,
	input wire regRead,
	output reg [31:0] regRdata,
	// Core sleep interface
	input wire busClockGateRequest,
	input wire debuggerClockRequest,
	input wire [`PMCG_WAKE_W-1:0] wakeEvents,
	// Outer clock generator handshake
	output reg fastClockRequest,
	input wire fastClockAcknowledge,
	// Clock enables, divider and oscillator controls
	output reg [`PMCG_CE_W-1:0] clockEnables,
	output reg [2:0] coreDividerSelect,
	output reg outerDivide128,
	output reg crystalEnable,
	output reg tickTimerRun,
	output reg wakeCtrlEnableAck,
	output reg wakeRequest,
	output reg [3:0] operatingMode
);

	reg [31:0] ctrl_q;
	reg [7:0] sysCtl_q;
	reg [`PMCG_WAKE_W-1:0] wakeEn_q;
	reg [`PMCG_WAKE_W-1:0] wakePend_q;
	reg [`PMCG_WAKE_W-1:0] wakePend_d;
	reg [3:0] mode_q;
	reg [3:0] mode_d;
	reg [`PMCG_CE_W-1:0] ceNext;
	reg [2:0] divNext;
	reg deepMode;
	reg wakeDeep;
	reg pllNeeded;
	wire keepAwake;
	wire wakeReqBit;
	wire deepSel;
	wire anyWake;

	assign keepAwake = ctrl_q[`PMCG_CTRL_KEEP_AWAKE];
	assign wakeReqBit = ctrl_q[`PMCG_CTRL_WAKE_REQ];
	assign deepSel = sysCtl_q[`PMCG_SYS_DEEP];
	// Only sources enabled in the wake controller may raise a wake request
	assign anyWake = |(wakeEvents & wakeEn_q);

	// Mode selection: the core's gate request and debug override drive it
	always @* begin
		mode_d = `PMCG_MODE_RUN;
		if (debuggerClockRequest) begin
			mode_d = `PMCG_MODE_DEBUG;
		end else if (busClockGateRequest && !anyWake) begin
			// Gate request follows the core's own sleep/wake policy
			if (!deepSel) begin
				mode_d = keepAwake ? `PMCG_MODE_SLEEP_PERIPHERALS_AWAKE : `PMCG_MODE_SLEEP;
			end else if (wakeReqBit && wakeCtrlEnableAck) begin
				mode_d = keepAwake ? `PMCG_MODE_WDEEP_PA : `PMCG_MODE_WDEEP;
			end else begin
				mode_d = keepAwake ? `PMCG_MODE_DEEP_PA : `PMCG_MODE_DEEP;
			end
		end
	end

	// Per-mode clock enables; stop is never entered, primary clock always runs
	always @* begin
		ceNext = {`PMCG_CE_W{1'b0}};
		deepMode = 1'b0;
		wakeDeep = 1'b0;
		pllNeeded = 1'b1;
		case (mode_d)
			`PMCG_MODE_DEBUG: begin
				ceNext = {`PMCG_CE_W{1'b1}};
			end
			`PMCG_MODE_RUN: begin
				ceNext[`PMCG_CE_WAKE] = 1'b1;
				ceNext[`PMCG_CE_TICK] = 1'b1;
				ceNext[`PMCG_CE_BUS] = 1'b1;
				ceNext[`PMCG_CE_PERIPH] = 1'b1;
			end
			`PMCG_MODE_SLEEP_PERIPHERALS_AWAKE: begin
				ceNext[`PMCG_CE_WAKE] = 1'b1;
				ceNext[`PMCG_CE_TICK] = 1'b1;
				ceNext[`PMCG_CE_PERIPH] = 1'b1;
			end
			`PMCG_MODE_DEEP_PA: begin
				ceNext[`PMCG_CE_WAKE] = 1'b1;
				ceNext[`PMCG_CE_TICK] = 1'b1;
				ceNext[`PMCG_CE_PERIPH] = 1'b1;
				deepMode = 1'b1;
			end
			`PMCG_MODE_WDEEP_PA: begin
				ceNext[`PMCG_CE_WAKE] = 1'b1;
				ceNext[`PMCG_CE_PERIPH] = 1'b1;
				deepMode = 1'b1;
			end
			`PMCG_MODE_SLEEP: begin
				ceNext[`PMCG_CE_WAKE] = 1'b1;
				ceNext[`PMCG_CE_TICK] = 1'b1;
			end
			`PMCG_MODE_DEEP: begin
				ceNext[`PMCG_CE_WAKE] = 1'b1;
				ceNext[`PMCG_CE_TICK] = 1'b1;
				deepMode = 1'b1;
			end
			`PMCG_MODE_WDEEP: begin
				ceNext[`PMCG_CE_WAKE] = 1'b1;
				deepMode = 1'b1;
				wakeDeep = 1'b1;
				pllNeeded = 1'b0;
			end
			default: begin
				// Stop enables nothing but is unreachable by design
				ceNext = {`PMCG_CE_W{1'b0}};
				pllNeeded = 1'b0;
			end
		endcase
	end

	// Divider: deep modes force divide-by-16 in place of the programmed select
	always @* begin
		divNext = ctrl_q[`PMCG_CTRL_DIV_MSB:`PMCG_CTRL_DIV_LSB];
		if (divNext > `PMCG_DIV_1) begin
			divNext = `PMCG_DIV_1;
		end
		if (deepMode) begin
			divNext = `PMCG_DEEP_DIV;
		end
	end

	// Pending wake interrupts are held while the interrupt controller is unclocked
	always @* begin
		wakePend_d = wakePend_q | (wakeEvents & wakeEn_q);
		if (regWrite && regAddr == `PMCG_ADDR_WAKE_PEND) begin
			// Set wins over a software clear in the same cycle
			wakePend_d = (wakePend_q & ~regWdata[`PMCG_WAKE_W-1:0]) | (wakeEvents & wakeEn_q);
		end
	end

	always @(posedge clk_sys) begin
		if (sys_rst) begin
			ctrl_q <= `PMCG_CTRL_RESET;
			sysCtl_q <= 8'h00;
			wakeEn_q <= {`PMCG_WAKE_W{1'b0}};
			wakePend_q <= {`PMCG_WAKE_W{1'b0}};
			mode_q <= `PMCG_MODE_RUN;
			clockEnables <= {`PMCG_CE_W{1'b0}};
			coreDividerSelect <= `PMCG_DIV_16;
			outerDivide128 <= `PMCG_OUTER_DIV128;
			crystalEnable <= 1'b1;
			tickTimerRun <= 1'b0;
			wakeCtrlEnableAck <= 1'b0;
			wakeRequest <= 1'b0;
			fastClockRequest <= 1'b0;
			operatingMode <= `PMCG_MODE_RUN;
			regRdata <= 32'h0000_0000;
		end else begin
			if (regWrite) begin
				case (regAddr)
					`PMCG_ADDR_CTRL: ctrl_q <= regWdata;
					`PMCG_ADDR_SYSCTL: sysCtl_q <= regWdata[7:0];
					`PMCG_ADDR_WAKE_EN: wakeEn_q <= regWdata[`PMCG_WAKE_W-1:0];
					default: ctrl_q <= ctrl_q;
				endcase
			end
			wakePend_q <= wakePend_d;
			mode_q <= mode_d;
			operatingMode <= mode_d;
			// Registered enables update on the rising edge, i.e. while the gated clock is high
			clockEnables <= ceNext;
			coreDividerSelect <= divNext;
			// The tick domain may stay enabled in deep sleep, but the timer itself must halt there
			tickTimerRun <= ceNext[`PMCG_CE_TICK] & ~deepMode;
			wakeCtrlEnableAck <= wakeReqBit;
			wakeRequest <= anyWake;
			crystalEnable <= ~wakeDeep;
			fastClockRequest <= pllNeeded;
			// Outer divider drops to /128 in wake deep sleep without keep-awake, back to /2 once the PLL is acknowledged
			if (wakeDeep) begin
				outerDivide128 <= `PMCG_OUTER_DIV128;
			end else if (fastClockRequest && fastClockAcknowledge) begin
				outerDivide128 <= `PMCG_OUTER_DIV2;
			end
			regRdata <= 32'h0000_0000;
			if (regRead) begin
				case (regAddr)
					`PMCG_ADDR_CTRL: regRdata <= ctrl_q;
					`PMCG_ADDR_SYSCTL: regRdata <= {24'h000000, sysCtl_q};
					`PMCG_ADDR_STATUS: regRdata <= {16'h0000, fastClockAcknowledge, fastClockRequest,
						wakeCtrlEnableAck, outerDivide128, mode_q, 3'h0, clockEnables};
					`PMCG_ADDR_WAKE_EN: regRdata <= {16'h0000, wakeEn_q};
					`PMCG_ADDR_WAKE_PEND: regRdata <= {16'h0000, wakePend_q};
					default: regRdata <= 32'h0000_0000;
				endcase
			end
		end
	end

endmodule // pmcg_power_mode_clock_gating
`default_nettype wire

// ---- logic/pmcg_regs.vh ----
// Constants for the power mode clock gating controller
`ifndef PMCG_REGS_VH
`define PMCG_REGS_VH

// Register offsets (byte addresses, one 32-bit word each)
`define PMCG_ADDR_CTRL 8'h00
`define PMCG_ADDR_SYSCTL 8'h04
`define PMCG_ADDR_STATUS 8'h08
`define PMCG_ADDR_WAKE_EN 8'h0c
`define PMCG_ADDR_WAKE_PEND 8'h10

// Control register fields
`define PMCG_CTRL_DIV_LSB 0
`define PMCG_CTRL_DIV_MSB 2
`define PMCG_CTRL_WAKE_REQ 4
`define PMCG_CTRL_STOP_REQ 5
`define PMCG_CTRL_KEEP_AWAKE 21
`define PMCG_CTRL_RESET 32'h0000_0000

// System control bits
`define PMCG_SYS_SLEEP_EXIT 1
`define PMCG_SYS_DEEP 2
`define PMCG_SYS_EVT_PEND 4

// Divider select codes: 000 is divide by 16
`define PMCG_DIV_16 3'h0
`define PMCG_DIV_8 3'h1
`define PMCG_DIV_4 3'h2
`define PMCG_DIV_2 3'h3
`define PMCG_DIV_1 3'h4
`define PMCG_DEEP_DIV 3'h0

// Operating mode codes
`define PMCG_MODE_DEBUG 4'h0
`define PMCG_MODE_RUN 4'h1
`define PMCG_MODE_SLEEP_PERIPHERALS_AWAKE 4'h2
`define PMCG_MODE_DEEP_PA 4'h3
`define PMCG_MODE_WDEEP_PA 4'h4
`define PMCG_MODE_SLEEP 4'h5
`define PMCG_MODE_DEEP 4'h6
`define PMCG_MODE_WDEEP 4'h7
`define PMCG_MODE_STOP 4'h8

// Clock enable vector bit positions
`define PMCG_CE_WAKE 0
`define PMCG_CE_TICK 1
`define PMCG_CE_BUS 2
`define PMCG_CE_PERIPH 3
`define PMCG_CE_DEBUG 4
`define PMCG_CE_W 5

// Outer generator divider select: 0 divide-by-two, 1 divide-by-128
`define PMCG_OUTER_DIV2 1'b0
`define PMCG_OUTER_DIV128 1'b1

`define PMCG_WAKE_W 16

`endif

// ---- verif/pmcg_pll_model.sv ----
// Outer clock generator model for the fast clock handshake
`timescale 1ns/1ps
`default_nettype none
module pmcg_pll_model #(parameter int LOCK_CYC = 4) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic sys_rst,
	// Handshake
	input wire logic fastClockRequest,
	output logic fastClockAcknowledge
);
	int lockCnt;
	// The PLL stops with the request, so lock restarts from zero each time
	always @(posedge clk_sys) begin
		if (sys_rst || !fastClockRequest) begin
			lockCnt <= 0;
			fastClockAcknowledge <= 1'b0;
		end else begin
			lockCnt <= lockCnt + 1;
			fastClockAcknowledge <= (lockCnt >= LOCK_CYC);
		end
	end
endmodule // pmcg_pll_model
`default_nettype wire

// ---- verif/pmcg_sva.sv ----
// Port assertions for the mode controller
`timescale 1ns/1ps
`default_nettype none
`include "pmcg_regs.vh"
module pmcg_sva (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic sys_rst,
	// Register writes
	input wire logic regWrite,
	input wire logic [7:0] regAddr,
	input wire logic [31:0] regWdata,
	// Mode inputs and outputs
	input wire logic debuggerClockRequest,
	input wire logic [15:0] wakeEvents,
	input wire logic fastClockRequest,
	input wire logic fastClockAcknowledge,
	input wire logic [4:0] clockEnables,
	input wire logic [2:0] coreDividerSelect,
	input wire logic outerDivide128,
	input wire logic crystalEnable,
	input wire logic tickTimerRun,
	input wire logic wakeCtrlEnableAck,
	input wire logic wakeRequest,
	input wire logic [3:0] operatingMode
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	logic deepMode;
	assign deepMode = operatingMode inside {`PMCG_MODE_DEEP_PA, `PMCG_MODE_WDEEP_PA, `PMCG_MODE_DEEP, `PMCG_MODE_WDEEP};
	sequence ctrlWrite;
		regWrite && regAddr == `PMCG_ADDR_CTRL;
	endsequence
	dbg_all_on_a: assert property (debuggerClockRequest |=> clockEnables == 5'h1f)
		else $error("debug enables");
	rst_run_a: assert property ($fell(sys_rst) |-> operatingMode == `PMCG_MODE_RUN && coreDividerSelect == 3'h0)
		else $error("reset mode");
	sleep_gate_a: assert property (operatingMode == `PMCG_MODE_SLEEP |-> clockEnables == 5'h03)
		else $error("sleep enables");
	pa_keep_a: assert property (operatingMode == `PMCG_MODE_SLEEP_PERIPHERALS_AWAKE |-> clockEnables == 5'h0b)
		else $error("sleep_peripherals_awake enables");
	deep_slow_a: assert property (deepMode |-> coreDividerSelect == 3'h0 && !tickTimerRun)
		else $error("deep divider");
	wdeep_osc_a: assert property (operatingMode == `PMCG_MODE_WDEEP |-> clockEnables == 5'h01 && !crystalEnable)
		else $error("wake deep");
	fast_req_a: assert property (!$past(sys_rst) && operatingMode != `PMCG_MODE_WDEEP |-> fastClockRequest)
		else $error("fast request");
	ack_copy_a: assert property (ctrlWrite ##1 !regWrite |=> wakeCtrlEnableAck == $past(regWdata[4], 2))
		else $error("enable ack");
	wake_src_a: assert property (wakeRequest |-> $past(|wakeEvents))
		else $error("wake request");
	outer_back_a: assert property ($fell(outerDivide128) |-> $past(fastClockRequest && fastClockAcknowledge))
		else $error("outer divider");
	no_stop_a: assert property (operatingMode != `PMCG_MODE_STOP)
		else $error("stop mode");
endmodule // pmcg_sva
bind pmcg_power_mode_clock_gating pmcg_sva i_sva (.clk_sys, .sys_rst, .regWrite, .regAddr, .regWdata,
	.debuggerClockRequest, .wakeEvents, .fastClockRequest, .fastClockAcknowledge, .clockEnables,
	.coreDividerSelect, .outerDivide128, .crystalEnable, .tickTimerRun, .wakeCtrlEnableAck, .wakeRequest,
	.operatingMode);
`default_nettype wire

// ---- verif/testbench.sv ----
// Self-checking bench for the mode controller
`timescale 1ns/1ps
`default_nettype none
`include "pmcg_regs.vh"
module testbench;
	logic clk_sys, sys_rst, regWrite, regRead, busClockGateRequest, debuggerClockRequest;
	logic [7:0] regAddr;
	logic [31:0] regWdata;
	logic [15:0] wakeEvents;
	wire [31:0] regRdata;
	wire fastClockRequest, fastClockAcknowledge, outerDivide128, crystalEnable, tickTimerRun;
	wire wakeCtrlEnableAck, wakeRequest;
	wire [4:0] clockEnables;
	wire [2:0] coreDividerSelect;
	wire [3:0] operatingMode;
	int errCount = 0;
	int cmpCount = 0;
	pmcg_power_mode_clock_gating i_dut (.clk_sys, .sys_rst, .regAddr, .regWdata, .regWrite, .regRead,
		.regRdata, .busClockGateRequest, .debuggerClockRequest, .wakeEvents, .fastClockRequest,
		.fastClockAcknowledge, .clockEnables, .coreDividerSelect, .outerDivide128, .crystalEnable,
		.tickTimerRun, .wakeCtrlEnableAck, .wakeRequest, .operatingMode);
	pmcg_pll_model i_pll (.clk_sys, .sys_rst, .fastClockRequest, .fastClockAcknowledge);
	initial begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		cmpCount++;
		if (got !== exp) begin
			errCount++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic giveVerdict;
		if (errCount == 0 && cmpCount > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		regAddr <= a;
		regWdata <= d;
		regWrite <= 1'b1;
		@(posedge clk_sys);
		regWrite <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clk_sys);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge clk_sys);
		regRead <= 1'b0;
		#1;
		chk("rdata", exp, regRdata);
	endtask
	// Register write plus one registered mode step fit in three edges
	task automatic mode(input logic [3:0] m);
		repeat (3) @(posedge clk_sys);
		#1;
		chk("mode", m, operatingMode);
	endtask
	task automatic outerBack;
		for (int i = 0; i < 30 && outerDivide128 !== 1'b0; i++)
			@(posedge clk_sys);
		#1;
		chk("outer128", 0, outerDivide128);
	endtask
	task automatic tReset;
		mode(`PMCG_MODE_RUN);
		chk("enables", 5'h0f, clockEnables);
		chk("div", `PMCG_DIV_16, coreDividerSelect);
		outerBack();
		rd(`PMCG_ADDR_CTRL, `PMCG_CTRL_RESET);
		rd(8'h40, 32'h0);
	endtask
	task automatic tDiv;
		for (int c = 0; c < 5; c++) begin
			wr(`PMCG_ADDR_CTRL, c);
			mode(`PMCG_MODE_RUN);
			chk("div", c, coreDividerSelect);
		end
	endtask
	task automatic tSleep;
		@(posedge clk_sys);
		busClockGateRequest <= 1'b1;
		mode(`PMCG_MODE_SLEEP);
		chk("enables", 5'h03, clockEnables);
		wr(`PMCG_ADDR_CTRL, 32'h0020_0004);
		mode(`PMCG_MODE_SLEEP_PERIPHERALS_AWAKE);
		chk("enables", 5'h0b, clockEnables);
		wr(`PMCG_ADDR_CTRL, 32'h4);
		wr(`PMCG_ADDR_SYSCTL, 32'h4);
		mode(`PMCG_MODE_DEEP);
		chk("div", `PMCG_DEEP_DIV, coreDividerSelect);
		chk("tick", 0, tickTimerRun);
		wr(`PMCG_ADDR_CTRL, 32'h14);
		mode(`PMCG_MODE_WDEEP);
		chk("ack", 1, wakeCtrlEnableAck);
		chk("enables", 5'h01, clockEnables);
		chk("xtal", 0, crystalEnable);
		chk("fastreq", 0, fastClockRequest);
		chk("outer128", 1, outerDivide128);
		@(posedge clk_sys);
		busClockGateRequest <= 1'b0;
		mode(`PMCG_MODE_RUN);
		outerBack();
		wr(`PMCG_ADDR_SYSCTL, 32'h0);
	endtask
	task automatic tDebug;
		@(posedge clk_sys);
		busClockGateRequest <= 1'b1;
		debuggerClockRequest <= 1'b1;
		mode(`PMCG_MODE_DEBUG);
		chk("enables", 5'h1f, clockEnables);
		@(posedge clk_sys);
		busClockGateRequest <= 1'b0;
		debuggerClockRequest <= 1'b0;
		mode(`PMCG_MODE_RUN);
	endtask
	task automatic tWake;
		wr(`PMCG_ADDR_WAKE_EN, 32'h1);
		wakeEvents <= 16'h0002;
		mode(`PMCG_MODE_RUN);
		chk("wakereq", 0, wakeRequest);
		rd(`PMCG_ADDR_WAKE_PEND, 32'h0);
		@(posedge clk_sys);
		wakeEvents <= 16'h0001;
		busClockGateRequest <= 1'b1;
		mode(`PMCG_MODE_RUN);
		chk("wakereq", 1, wakeRequest);
		rd(`PMCG_ADDR_WAKE_PEND, 32'h1);
		wr(`PMCG_ADDR_WAKE_PEND, 32'h1);
		rd(`PMCG_ADDR_WAKE_PEND, 32'h1);
		@(posedge clk_sys);
		wakeEvents <= 16'h0000;
		wr(`PMCG_ADDR_WAKE_PEND, 32'h1);
		rd(`PMCG_ADDR_WAKE_PEND, 32'h0);
	endtask
	initial begin
		sys_rst = 1'b1;
		regWrite = 1'b0;
		regRead = 1'b0;
		regAddr = 8'h00;
		regWdata = 32'h0;
		busClockGateRequest = 1'b0;
		debuggerClockRequest = 1'b0;
		wakeEvents = 16'h0;
		repeat (12) @(posedge clk_sys);
		sys_rst <= 1'b0;
		tReset();
		tDiv();
		tSleep();
		tDebug();
		tWake();
		giveVerdict();
	end
	initial begin
		repeat (3000) @(posedge clk_sys);
		errCount++;
		giveVerdict();
	end
endmodule // testbench
`default_nettype wire
